// ---- hdl/accel_trim_range_fifo_ctrl.v ----
// Overview of operation
// - Range code 0..4 selects 2,4,8,16,12 g; codes 5..7 are reserved.
// - Results are sign-extended two's complement on out_x, out_y, out_z; output addresses 0x0d-0x12 read as zero.
// - Lowpass enable 0 bypasses the filter; 1 applies it.
// - Bandwidth code 1,2,3,5 divides internal rate by 4.255,6,12,16; others reserved.
// - Per-axis signed 15-bit offset, low byte plus bits 6:0 of next.
// - Offsets and gains preload from fuses at reset; host writes overwrite.
// - Per-axis 9-bit gain; bit 8 lives in bit 7 of high offset.
// - Queue full interrupt enabled only by control bit 1, default off.
// - Queue watermark interrupt enabled by control bit 2 and needs enable bit 5 set, default off.
// - Merge bit 0 splits requests over two pins; 1 sends all to first.
// - Queue reset clears pointers and control logic, keeps stored samples.
// - Queue and its operations disabled while enable bit is 0.
// - Mode 1 drops new samples once count reaches watermark level.
// - Watermark level is 5 bits, resets to 0x10, host uses 1..31.
// - Bits 7:5 of watermark register read as zero.
// - Filter cutoff follows the undecimated internal sample rate.
//
// Purpose: range, filter, trim and sample queue control for the accelerometer
// Assumes: register port gives address, write strobe, read strobe, byte data
// Notes: trim registers are write-only from the port but readable internally
`timescale 1ns/1ps
`default_nettype none
`include "accel_trim_defs.vh"
module accel_trim_range_fifo_ctrl #(
	parameter SAMPLE_W = 48,
	parameter PTR_W = `QUEUE_PTR_W
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Register port
	input wire [6:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// Fuse preload values
	input wire [14:0] fuse_x_offset,
	input wire [14:0] fuse_y_offset,
	input wire [14:0] fuse_z_offset,
	input wire [8:0] fuse_x_scale,
	input wire [8:0] fuse_y_scale,
	input wire [8:0] fuse_z_scale,
	// Raw samples from the converter at the internal sample rate
	input wire raw_valid,
	input wire [15:0] raw_x,
	input wire [15:0] raw_y,
	input wire [15:0] raw_z,
	// Interrupt requests from the rest of the device
	input wire motion_irq_req,
	// Conditioned result out
	output reg [15:0] out_x,
	output reg [15:0] out_y,
	output reg [15:0] out_z,
	output reg out_strobe,
	// Queue drain
	output wire q_out_valid,
	input wire q_out_ready,
	output wire [SAMPLE_W-1:0] q_out_data,
	output reg [PTR_W:0] q_count,
	// Decoded settings
	output reg [4:0] range_g,
	output reg range_reserved,
	output reg [4:0] cutoff_div_x1000_sel,
	// Interrupt pins, active low, open drain style
	output reg first_irq_pin_n,
	output reg second_irq_pin_n
);
	// Stored configuration
	reg [7:0] range_cfg_q;
	reg [14:0] x_axis_trim_offset_q;
	reg [14:0] y_axis_trim_offset_q;
	reg [14:0] z_axis_trim_offset_q;
	reg [8:0] x_axis_trim_scale_q;
	reg [8:0] y_axis_trim_scale_q;
	reg [8:0] z_axis_trim_scale_q;
	reg [7:0] qctrl_q;
	reg [4:0] queue_watermark_level_q;
	reg fuse_loaded_q;

	wire lowpass_enable;
	wire [2:0] lowpass_bandwidth_select;
	wire [2:0] range_sel;
	wire queue_full_irq_enable;
	wire queue_watermark_irq_enable;
	wire merge_irq_to_first_pin;
	wire queue_reset;
	wire queue_enable;
	wire queue_stop_mode;

	assign range_sel = range_cfg_q[`RANGE_LSB+2:`RANGE_LSB];
	assign lowpass_enable = range_cfg_q[`LOWPASS_EN_BIT];
	assign lowpass_bandwidth_select = range_cfg_q[2:0];
	assign queue_full_irq_enable = qctrl_q[`QC_FULL_IRQ_EN];
	assign queue_watermark_irq_enable = qctrl_q[`QC_WMARK_IRQ_EN];
	assign merge_irq_to_first_pin = qctrl_q[`QC_MERGE_IRQ];
	assign queue_reset = qctrl_q[`QC_RESET];
	assign queue_enable = qctrl_q[`QC_ENABLE];
	assign queue_stop_mode = qctrl_q[`QC_MODE];

	// Register writes; fuse preload one cycle after reset release
	always @(posedge clk) begin
		if (!rst_n) begin
			range_cfg_q <= `RST_RANGE_FILTER;
			qctrl_q <= `RST_QUEUE_CTRL;
			queue_watermark_level_q <= `RST_QUEUE_WMARK;
			fuse_loaded_q <= 1'b0;
			x_axis_trim_offset_q <= 15'h0000;
			y_axis_trim_offset_q <= 15'h0000;
			z_axis_trim_offset_q <= 15'h0000;
			x_axis_trim_scale_q <= 9'h000;
			y_axis_trim_scale_q <= 9'h000;
			z_axis_trim_scale_q <= 9'h000;
		end else if (!fuse_loaded_q) begin
			// Fuse ports are sampled clocked, never under reset
			fuse_loaded_q <= 1'b1;
			x_axis_trim_offset_q <= fuse_x_offset;
			y_axis_trim_offset_q <= fuse_y_offset;
			z_axis_trim_offset_q <= fuse_z_offset;
			x_axis_trim_scale_q <= fuse_x_scale;
			y_axis_trim_scale_q <= fuse_y_scale;
			z_axis_trim_scale_q <= fuse_z_scale;
		end else if (reg_wr) begin
			case (reg_addr)
			`ADDR_RANGE_FILTER: range_cfg_q <= reg_wdata;
			`ADDR_X_OFF_LOW: x_axis_trim_offset_q[7:0] <= reg_wdata;
			`ADDR_X_OFF_HIGH: begin
				x_axis_trim_offset_q[14:8] <= reg_wdata[6:0];
				x_axis_trim_scale_q[8] <= reg_wdata[7];
			end
			`ADDR_Y_OFF_LOW: y_axis_trim_offset_q[7:0] <= reg_wdata;
			`ADDR_Y_OFF_HIGH: begin
				y_axis_trim_offset_q[14:8] <= reg_wdata[6:0];
				y_axis_trim_scale_q[8] <= reg_wdata[7];
			end
			`ADDR_Z_OFF_LOW: z_axis_trim_offset_q[7:0] <= reg_wdata;
			`ADDR_Z_OFF_HIGH: begin
				z_axis_trim_offset_q[14:8] <= reg_wdata[6:0];
				z_axis_trim_scale_q[8] <= reg_wdata[7];
			end
			`ADDR_X_GAIN: x_axis_trim_scale_q[7:0] <= reg_wdata;
			`ADDR_Y_GAIN: y_axis_trim_scale_q[7:0] <= reg_wdata;
			`ADDR_Z_GAIN: z_axis_trim_scale_q[7:0] <= reg_wdata;
			`ADDR_QUEUE_CTRL: qctrl_q <= reg_wdata;
			`ADDR_QUEUE_WMARK: queue_watermark_level_q <= reg_wdata[4:0];
			default: fuse_loaded_q <= fuse_loaded_q;
			endcase
		end
	end

	// Readback: only queue registers are readable; write-only return zero
	always @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`ADDR_QUEUE_CTRL: reg_rdata <= qctrl_q;
			`ADDR_QUEUE_WMARK: reg_rdata <= {3'h0, queue_watermark_level_q};
			default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Range and bandwidth decode, registered for the datapath
	always @(posedge clk) begin
		if (!rst_n) begin
			range_g <= 5'h02;
			range_reserved <= 1'b0;
			cutoff_div_x1000_sel <= 5'h00;
		end else begin
			range_reserved <= 1'b0;
			case (range_sel)
			3'h0: range_g <= 5'h02;
			3'h1: range_g <= 5'h04;
			3'h2: range_g <= 5'h08;
			3'h3: range_g <= 5'h10;
			3'h4: range_g <= 5'h0c;
			default: begin
				range_g <= range_g;
				range_reserved <= 1'b1;
			end
			endcase
			// Cutoff divider index, relative to the internal rate
			case (lowpass_bandwidth_select)
			`BW_DIV_4P255: cutoff_div_x1000_sel <= 5'h01;
			`BW_DIV_6: cutoff_div_x1000_sel <= 5'h02;
			`BW_DIV_12: cutoff_div_x1000_sel <= 5'h03;
			`BW_DIV_16: cutoff_div_x1000_sel <= 5'h05;
			default: cutoff_div_x1000_sel <= 5'h00;
			endcase
		end
	end

	// Simple one-pole smoothing, shift chosen by bandwidth code
	reg [17:0] filt_x_q;
	reg [17:0] filt_y_q;
	reg [17:0] filt_z_q;
	reg [1:0] shift_sel;
	reg push_strobe_q;
	always @* begin
		case (lowpass_bandwidth_select)
		`BW_DIV_4P255: shift_sel = 2'h0;
		`BW_DIV_6: shift_sel = 2'h1;
		`BW_DIV_12: shift_sel = 2'h2;
		`BW_DIV_16: shift_sel = 2'h3;
		default: shift_sel = 2'h0;
		endcase
	end

	function [17:0] lp_step;
		input [17:0] acc;
		input [15:0] smp;
		input [1:0] sh;
		reg signed [17:0] diff;
		begin
			diff = $signed({{2{smp[15]}}, smp}) - $signed(acc);
			// Signed sum keeps the shift arithmetic; 3-bit amount gives 1..4
			lp_step = $signed(acc) + (diff >>> ({1'b0, sh} + 3'h1));
		end
	endfunction

	// Offset then gain; gain 256 is unity, result saturates to 16 bits
	function [15:0] trim;
		input [17:0] v;
		input [14:0] off;
		input [8:0] g;
		reg signed [18:0] s;
		reg signed [28:0] p;
		begin
			s = $signed({v[17], v}) + $signed({{4{off[14]}}, off});
			p = (s * $signed({1'b0, g})) >>> 8;
			if (p > 29'sd32767) trim = 16'h7fff;
			else if (p < -29'sd32768) trim = 16'h8000;
			else trim = p[15:0];
		end
	endfunction

	// Filter runs on every raw sample so cutoff tracks the internal rate
	always @(posedge clk) begin
		if (!rst_n) begin
			filt_x_q <= 18'h00000;
			filt_y_q <= 18'h00000;
			filt_z_q <= 18'h00000;
			out_x <= 16'h0000;
			out_y <= 16'h0000;
			out_z <= 16'h0000;
			out_strobe <= 1'b0;
			push_strobe_q <= 1'b0;
		end else begin
			out_strobe <= raw_valid;
			// Trimmed word settles one cycle after the strobe; queue waits for it
			push_strobe_q <= out_strobe;
			if (raw_valid) begin
				if (lowpass_enable) begin
					filt_x_q <= lp_step(filt_x_q, raw_x, shift_sel);
					filt_y_q <= lp_step(filt_y_q, raw_y, shift_sel);
					filt_z_q <= lp_step(filt_z_q, raw_z, shift_sel);
				end else begin
					filt_x_q <= {{2{raw_x[15]}}, raw_x};
					filt_y_q <= {{2{raw_y[15]}}, raw_y};
					filt_z_q <= {{2{raw_z[15]}}, raw_z};
				end
			end
			out_x <= trim(filt_x_q, x_axis_trim_offset_q, x_axis_trim_scale_q);
			out_y <= trim(filt_y_q, y_axis_trim_offset_q, y_axis_trim_scale_q);
			out_z <= trim(filt_z_q, z_axis_trim_offset_q, z_axis_trim_scale_q);
		end
	end

	// Queue pointers and count
	reg [PTR_W-1:0] wr_ptr_q;
	reg [PTR_W-1:0] rd_ptr_q;
	reg rd_pend_q;
	wire q_full;
	wire q_at_mark;
	wire q_push;
	wire q_pop;
	wire buf_in_ready;
	wire q_hold;

	assign q_hold = queue_reset || !queue_enable;
	assign q_full = (q_count == {1'b1, {PTR_W{1'b0}}}); // Depth is 2**PTR_W
	assign q_at_mark = (q_count >= {1'b0, queue_watermark_level_q});
	assign q_push = push_strobe_q && !q_hold && !q_full
		&& !(queue_stop_mode && q_at_mark);
	// One word in flight from memory to buffer; stall when buffer full
	assign q_pop = !q_hold && (q_count != {(PTR_W+1){1'b0}}) && buf_in_ready
		&& !rd_pend_q;

	always @(posedge clk) begin
		if (!rst_n || q_hold) begin
			wr_ptr_q <= {PTR_W{1'b0}};
			rd_ptr_q <= {PTR_W{1'b0}};
			q_count <= {(PTR_W+1){1'b0}};
			rd_pend_q <= 1'b0;
		end else begin
			rd_pend_q <= q_pop;
			if (q_push) wr_ptr_q <= wr_ptr_q + 1'b1;
			if (q_pop) rd_ptr_q <= rd_ptr_q + 1'b1;
			case ({q_push, q_pop})
			2'b10: q_count <= q_count + 1'b1;
			2'b01: q_count <= q_count - 1'b1;
			default: q_count <= q_count;
			endcase
		end
	end

	wire [SAMPLE_W-1:0] mem_rd;
	sample_store #(.WIDTH(SAMPLE_W), .ADDR_W(PTR_W)) u_store (
		.clk(clk),
		.wr_en(q_push),
		.wr_addr(wr_ptr_q),
		.wr_data({out_z, out_y, out_x}),
		.rd_addr(rd_ptr_q),
		.rd_data(mem_rd)
	);

	skid_buffer #(.WIDTH(SAMPLE_W)) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.flush(q_hold),
		.in_valid(rd_pend_q),
		.in_ready(buf_in_ready),
		.in_data(mem_rd),
		.out_valid(q_out_valid),
		.out_ready(q_out_ready),
		.out_data(q_out_data)
	);

	// Interrupt routing; queue requests gated by their enables
	wire q_irq;
	assign q_irq = (queue_full_irq_enable && q_full)
		|| (queue_watermark_irq_enable && q_at_mark && queue_enable);
	always @(posedge clk) begin
		if (!rst_n) begin
			first_irq_pin_n <= 1'b1;
			second_irq_pin_n <= 1'b1;
		end else if (merge_irq_to_first_pin) begin
			first_irq_pin_n <= !(motion_irq_req || q_irq);
			second_irq_pin_n <= 1'b1;
		end else begin
			first_irq_pin_n <= !motion_irq_req;
			second_irq_pin_n <= !q_irq;
		end
	end
endmodule // accel_trim_range_fifo_ctrl
`default_nettype wire

// ---- hdl/accel_trim_defs.vh ----
// Purpose: constants for the range, trim and sample queue control block
// Assumes: 8-bit register port, 7-bit register addresses
// Notes: trim preload values arrive from the fuse array ports
`ifndef ACCEL_TRIM_DEFS_VH
`define ACCEL_TRIM_DEFS_VH

`define ADDR_RANGE_FILTER 7'h20
`define ADDR_X_OFF_LOW 7'h21
`define ADDR_X_OFF_HIGH 7'h22
`define ADDR_Y_OFF_LOW 7'h23
`define ADDR_Y_OFF_HIGH 7'h24
`define ADDR_Z_OFF_LOW 7'h25
`define ADDR_Z_OFF_HIGH 7'h26
`define ADDR_X_GAIN 7'h27
`define ADDR_Y_GAIN 7'h28
`define ADDR_Z_GAIN 7'h29
`define ADDR_QUEUE_CTRL 7'h2d
`define ADDR_QUEUE_WMARK 7'h2e
`define ADDR_OUT_FIRST 7'h0d
`define ADDR_OUT_LAST 7'h12

`define RST_RANGE_FILTER 8'h00
`define RST_QUEUE_CTRL 8'h00
`define RST_QUEUE_WMARK 5'h10

`define QC_FULL_IRQ_EN 1
`define QC_WMARK_IRQ_EN 2
`define QC_MERGE_IRQ 3
`define QC_RESET 4
`define QC_ENABLE 5
`define QC_MODE 6

`define RANGE_LSB 4
`define LOWPASS_EN_BIT 3

`define BW_DIV_4P255 3'h1
`define BW_DIV_6 3'h2
`define BW_DIV_12 3'h3
`define BW_DIV_16 3'h5

`define QUEUE_DEPTH 32
`define QUEUE_PTR_W 5

`endif

// ---- hdl/sample_store.v ----
// Purpose: sample queue storage, one write port, registered read port
// Assumes: single clock, write and read addresses from the controller
// Notes: contents hold across queue reset; only pointers clear
`timescale 1ns/1ps
`default_nettype none
module sample_store #(
	parameter WIDTH = 48,
	parameter ADDR_W = 5
) (
	// Clock
	input wire clk,
	// Write port
	input wire wr_en,
	input wire [ADDR_W-1:0] wr_addr,
	input wire [WIDTH-1:0] wr_data,
	// Read port
	input wire [ADDR_W-1:0] rd_addr,
	output reg [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

	// No reset on the array, so a queue reset leaves the words alone
	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // sample_store
`default_nettype wire

// ---- hdl/skid_buffer.v ----
// Purpose: two-entry valid/ready buffer in the sample output path
// Assumes: single clock, synchronous active-low reset
// Notes: in_ready is decoded from the registered count and low only when both entries are full
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
	parameter WIDTH = 48
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	input wire flush,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] ent0_q;
	reg [WIDTH-1:0] ent1_q;
	reg [1:0] cnt_q;
	reg valid_q;
	wire push;
	wire pop;

	assign push = in_valid && (cnt_q != 2'h2);
	assign pop = (cnt_q != 2'h0) && out_ready;
	assign in_ready = (cnt_q != 2'h2);
	// Valid kept in its own flop so the drain side sees no decode logic
	assign out_valid = valid_q;
	assign out_data = ent0_q;

	// Entry 0 is always the head; entry 1 shifts down on a pop
	always @(posedge clk) begin
		if (!rst_n || flush) begin
			cnt_q <= 2'h0;
			valid_q <= 1'b0;
			ent0_q <= {WIDTH{1'b0}};
			ent1_q <= {WIDTH{1'b0}};
		end else begin
			case ({push, pop})
			2'b10: begin
				if (cnt_q == 2'h0) ent0_q <= in_data;
				else ent1_q <= in_data;
				cnt_q <= cnt_q + 2'h1;
				valid_q <= 1'b1;
			end
			2'b01: begin
				ent0_q <= ent1_q;
				cnt_q <= cnt_q - 2'h1;
				valid_q <= (cnt_q == 2'h2);
			end
			2'b11: begin
				if (cnt_q == 2'h1) ent0_q <= in_data;
				else begin
					ent0_q <= ent1_q;
					ent1_q <= in_data;
				end
			end
			default: begin
				cnt_q <= cnt_q;
			end
			endcase
		end
	end
endmodule // skid_buffer
`default_nettype wire

// ---- tb/accel_ctrl_chk_sva.sv ----
// Purpose: port checker for range, trim and queue control
// Assumes: queue settings tracked from host writes
// Notes: pin checks wait until settings are steady
`timescale 1ns/1ps
`default_nettype none
module accel_ctrl_chk #(
	parameter PTR_W = 5
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Register port
	input wire [6:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	// Status and pins
	input wire raw_valid,
	input wire out_strobe,
	input wire [PTR_W:0] q_count,
	input wire [4:0] range_g,
	input wire range_reserved,
	input wire [4:0] cutoff_div_x1000_sel,
	input wire first_irq_pin_n,
	input wire second_irq_pin_n
);
	reg [7:0] ctrl_q;
	reg [4:0] wm_q;
	// Shadow copies, since the control register is not visible here
	always @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= 8'h00;
			wm_q <= 5'h10;
		end else if (reg_wr && reg_addr == 7'h2d) begin
			ctrl_q <= reg_wdata;
		end else if (reg_wr && reg_addr == 7'h2e) begin
			wm_q <= reg_wdata[4:0];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_cfg_wr;
		reg_wr && reg_addr == 7'h20;
	endsequence
	sequence s_steady;
		$stable(ctrl_q) && $stable(wm_q);
	endsequence
	property p_wm_read;
		reg_rd && reg_addr == 7'h2e |=> reg_rdata == {3'h0, wm_q};
	endproperty
	a_wm_read: assert property (p_wm_read)
		else $error("level read wrong");
	property p_rng16;
		s_cfg_wr ##0 reg_wdata[6:4] == 3'h3 |-> ##[1:2] range_g == 5'd16;
	endproperty
	a_rng16: assert property (p_rng16)
		else $error("range code 3 wrong");
	property p_rsv;
		s_cfg_wr ##0 reg_wdata[6:4] > 3'h4 |-> ##[1:2] range_reserved;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved range missed");
	property p_bw;
		s_cfg_wr ##0 reg_wdata[2:0] == 3'h4 |-> ##[1:2]
			cutoff_div_x1000_sel == 5'h0;
	endproperty
	a_bw: assert property (p_bw)
		else $error("reserved bandwidth used");
	property p_strobe;
		raw_valid |=> out_strobe;
	endproperty
	a_strobe: assert property (p_strobe)
		else $error("no result strobe");
	property p_qoff;
		s_steady ##0 (!ctrl_q[5] || ctrl_q[4]) |-> q_count == 0;
	endproperty
	a_qoff: assert property (p_qoff)
		else $error("queue not cleared");
	property p_mode;
		s_steady ##0 (ctrl_q[6] && q_count >= wm_q) |=>
			q_count <= $past(q_count);
	endproperty
	a_mode: assert property (p_mode)
		else $error("stored past level");
	property p_full;
		s_steady ##0 (ctrl_q[1] && !ctrl_q[3] && q_count == (1 << PTR_W))
			|=> !second_irq_pin_n;
	endproperty
	a_full: assert property (p_full)
		else $error("full request missing");
	property p_wmark;
		s_steady ##0 (ctrl_q[2] && ctrl_q[5] && !ctrl_q[3] &&
			q_count >= wm_q) |=> !second_irq_pin_n;
	endproperty
	a_wmark: assert property (p_wmark)
		else $error("level request missing");
	property p_merge;
		s_steady ##0 (ctrl_q[3] || ctrl_q[2:1] == 2'h0) |=> second_irq_pin_n;
	endproperty
	a_merge: assert property (p_merge)
		else $error("second pin active");
endmodule // accel_ctrl_chk
bind accel_trim_range_fifo_ctrl accel_ctrl_chk #(.PTR_W(PTR_W)) chk_u (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.raw_valid(raw_valid), .out_strobe(out_strobe), .q_count(q_count),
	.range_g(range_g), .range_reserved(range_reserved),
	.cutoff_div_x1000_sel(cutoff_div_x1000_sel),
	.first_irq_pin_n(first_irq_pin_n), .second_irq_pin_n(second_irq_pin_n));
`default_nettype wire

// ---- tb/queue_sink.sv ----
// Purpose: drain-side model taking words from the queue output
// Assumes: bench holds stall as long as it likes
// Notes: ready is registered, so a stall acts one cycle late
`timescale 1ns/1ps
`default_nettype none
module queue_sink (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Bench control
	input wire stall,
	// Drain handshake
	input wire q_out_valid,
	output logic q_out_ready,
	output logic [7:0] pops
);
	// Accept when not stalled; count words taken
	always @(posedge clk) begin
		if (!rst_n) begin
			q_out_ready <= 1'b0;
			pops <= 8'h00;
		end else begin
			q_out_ready <= !stall;
			pops <= pops + {7'h0, q_out_valid && q_out_ready};
		end
	end
endmodule // queue_sink
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: self-checking bench for range, trim and queue control
// Assumes: 100 MHz clock, reset held 20 cycles
// Notes: trim checks run with the filter bypassed, except the last z-axis check at bandwidth code 1
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst_n, reg_wr, reg_rd, raw_valid, motion_irq_req, stall;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, rd_v;
	logic [15:0] raw_x, raw_y, raw_z;
	logic [44:0] fuse;
	logic [14:0] off;
	logic [15:0] pz;
	logic [4:0] wm, last_g;
	logic [2:0] b;
	wire [7:0] reg_rdata, pops;
	wire [15:0] out_x, out_y, out_z;
	wire [47:0] q_out_data;
	wire [5:0] q_count;
	wire [4:0] range_g, bw_sel;
	wire out_strobe, q_out_valid, q_out_ready, range_reserved, p1_n, p2_n;
	wire [47:0] ov = {out_z, out_y, out_x};
	wire [47:0] rv = {raw_z, raw_y, raw_x};
	int n_errors, num_checks, cyc;
	accel_trim_range_fifo_ctrl dut_u (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.fuse_x_offset(fuse[14:0]), .fuse_y_offset(fuse[29:15]),
		.fuse_z_offset(fuse[44:30]), .fuse_x_scale(9'h100),
		.fuse_y_scale(9'h100), .fuse_z_scale(9'h100),
		.raw_valid(raw_valid), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
		.motion_irq_req(motion_irq_req), .out_x(out_x), .out_y(out_y),
		.out_z(out_z), .out_strobe(out_strobe), .q_out_valid(q_out_valid),
		.q_out_ready(q_out_ready), .q_out_data(q_out_data),
		.q_count(q_count), .range_g(range_g),
		.range_reserved(range_reserved), .cutoff_div_x1000_sel(bw_sel),
		.first_irq_pin_n(p1_n), .second_irq_pin_n(p2_n));
	queue_sink sink_u (.clk(clk), .rst_n(rst_n), .stall(stall),
		.q_out_valid(q_out_valid), .q_out_ready(q_out_ready), .pops(pops));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [6:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask
	// Spaced samples, then time for the pipeline to settle
	task automatic push(input int n);
		repeat (n) begin
			@(posedge clk);
			raw_valid <= 1'b1;
			raw_x <= 16'($urandom_range(0, 511));
			raw_y <= 16'($urandom_range(0, 511));
			raw_z <= 16'($urandom_range(0, 511));
			@(posedge clk);
			raw_valid <= 1'b0;
		end
		repeat (8) @(posedge clk);
		#1;
	endtask
	function automatic logic [4:0] g_of(input int c);
		logic [4:0] t [5] = '{5'd2, 5'd4, 5'd8, 5'd16, 5'd12};
		return t[c];
	endfunction
	function automatic logic [15:0] sx(input logic [14:0] v);
		return {v[14], v};
	endfunction
	// One-pole step at bandwidth code 1: half the difference is taken
	function automatic logic [15:0] lp1(input logic [15:0] p,
		input logic [15:0] r);
		logic signed [17:0] d;
		d = $signed({2'b00, r}) - $signed({2'b00, p});
		return p + 16'(d >>> 1);
	endfunction
	// Main sequence
	initial begin
		void'($urandom(32'hf3ab));
		{rst_n, reg_wr, reg_rd, raw_valid, motion_irq_req, stall} = 6'h0;
		{reg_addr, reg_wdata, raw_x, raw_y, raw_z} = 63'h0;
		for (int i = 0; i < 3; i++)
			fuse[15*i +: 15] = 15'($urandom_range(0, 2047)) - 15'd1024;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(7'h2d);
		chk(rd_v, 8'h00);
		rd(7'h2e);
		chk(rd_v, 8'h10);
		wr(7'h2e, 8'hff);
		rd(7'h2e);
		chk(rd_v, 8'h1f);
		$display("reset and level done");
		for (int i = 0; i < 3; i++) begin
			push(1);
			chk(ov[16*i +: 16], rv[16*i +: 16] + sx(fuse[15*i +: 15]));
			off = 15'($urandom_range(0, 4095)) - 15'd2048;
			wr(7'(8'h21 + 2 * i), off[7:0]);
			wr(7'(8'h22 + 2 * i), {1'b1, off[14:8]});
			push(1);
			chk(ov[16*i +: 16], rv[16*i +: 16] + sx(off));
			wr(7'(8'h22 + 2 * i), {1'b0, off[14:8]});
			push(1);
			chk(ov[16*i +: 16], 16'h0000);
			wr(7'(8'h22 + 2 * i), {1'b1, off[14:8]});
		end
		pz = rv[47:32];
		wr(7'h20, 8'h09);
		push(1);
		chk(ov[47:32], lp1(pz, rv[47:32]) + sx(off));
		$display("trim done");
		last_g = 5'd2;
		for (int c = 0; c < 8; c++) begin
			b = 3'($urandom_range(0, 7));
			wr(7'h20, {1'b0, 3'(c), 1'b0, b});
			if (c < 5)
				last_g = g_of(c);
			chk(range_g, last_g);
			chk(range_reserved, c > 4);
			chk(bw_sel, (b == 1 || b == 2 || b == 3 || b == 5) ? b : 0);
		end
		$display("range done");
		stall <= 1'b1;
		wr(7'h2d, 8'h22);
		push(40);
		chk(q_count, 6'd32);
		chk(p2_n, 1'b0);
		@(posedge clk);
		motion_irq_req <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(p1_n, 1'b0);
		@(posedge clk);
		motion_irq_req <= 1'b0;
		wr(7'h2d, 8'h2a);
		chk({p1_n, p2_n}, 2'b01);
		wr(7'h2d, 8'h32);
		chk(q_count, 6'd0);
		push(3);
		chk(q_count, 6'd0);
		wr(7'h2d, 8'h22);
		push(1);
		chk(q_out_valid, 1'b1);
		chk(q_out_data[15:0], ov[15:0]);
		chk(q_out_data[47:32], ov[47:32]);
		stall <= 1'b0;
		push(2);
		repeat (60) @(posedge clk);
		#1;
		chk(q_count, 6'd0);
		chk(pops, 8'd3);
		chk(p2_n, 1'b1);
		$display("queue full done");
		stall <= 1'b1;
		wm = 5'($urandom_range(2, 20));
		wr(7'h2e, {3'h0, wm});
		wr(7'h2d, 8'h64);
		push(int'(wm) + 10);
		chk(q_count, {1'b0, wm});
		chk(p2_n, 1'b0);
		wr(7'h2d, 8'h24);
		push(5);
		chk(q_count, 6'(wm + 5));
		wr(7'h2d, 8'h00);
		chk(q_count, 6'd0);
		chk({p1_n, p2_n}, 2'b11);
		stall <= 1'b0;
		$display("queue mode done");
		stop_test();
	end
endmodule // tb
`default_nettype wire
